// ===== spi_dev_model.sv
// Peripheral model standing at the far end of the serial link
`timescale 1ns/1ns

module spi_dev_model (
	input  wire logic       sclk,
	input  wire logic       sel_n,
	input  wire logic       mosi,
	input  wire logic [7:0] resp_byte,
	output logic            miso,
	output logic [7:0]      got_byte
);
	logic [7:0] sh = 8'h00;
	int         n = 0;
	logic       drv = 1'b0;

	initial got_byte = 8'h00;
	always @(negedge sel_n)
	begin
		sh = resp_byte;
		n = 0;
		drv = 1'b1;
	end
	always @(posedge sel_n) drv = 1'b0;
	always @(posedge sclk)
	begin
		if (!sel_n) got_byte = {got_byte[6:0], mosi};
		if (!sel_n) n = n + 1;
	end
	always @(negedge sclk) if (!sel_n && n > 0 && n < 8) sh = {sh[6:0], ~sh[0]};
	// Released line shows the inverse of the last bit
	assign miso = drv ? sh[7] : ~sh[7];
endmodule : spi_dev_model

// ===== spi_halt_pkg.sv
// Constants for the clock-halt serial port block
package spi_halt_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [4:0] CTRL_OFFSET   = 5'h00;
	localparam logic [4:0] DIV_OFFSET    = 5'h04;
	localparam logic [4:0] TXDATA_OFFSET = 5'h08;
	localparam logic [4:0] RXDATA_OFFSET = 5'h0C;
	localparam logic [4:0] STATUS_OFFSET = 5'h10;

	// ----------------------------------------------------------------
	// Control field positions
	// ----------------------------------------------------------------
	localparam int CTRL_ENABLE_BIT  = 0;
	localparam int CTRL_MODE_LSB    = 1;
	localparam int CTRL_TXCP_BIT    = 3;
	localparam int CTRL_RXSP_BIT    = 4;
	localparam int CTRL_TXSP_BIT    = 5;
	localparam int CTRL_SRC_BIT     = 6;
	localparam int CTRL_TXCD_BIT    = 7;
	localparam int CTRL_RXCD_BIT    = 8;
	localparam int CTRL_TXSD_BIT    = 9;
	localparam int CTRL_RXSD_BIT    = 10;
	localparam int CTRL_WIDTH       = 11;

	// ----------------------------------------------------------------
	// Status field positions
	// ----------------------------------------------------------------
	localparam int STAT_BUSY_BIT    = 0;
	localparam int STAT_RXRDY_BIT   = 1;
	localparam int STAT_SEL_BIT     = 2;
	localparam int STAT_SCLK_BIT    = 3;
	localparam int STAT_RXSEL_BIT   = 4;

	// ----------------------------------------------------------------
	// Reset values and sizes
	// ----------------------------------------------------------------
	localparam logic [10:0] CTRL_RESET  = 11'h040;
	localparam logic [7:0]  DIV_RESET   = 8'h01;
	localparam int          WORD_BITS   = 8;
	localparam logic [3:0]  WORD_BITS_C = 4'h8;

	// ----------------------------------------------------------------
	// Clock halt mode codes
	// ----------------------------------------------------------------
	localparam logic [1:0] HALT_NO_DELAY   = 2'h2;
	localparam logic [1:0] HALT_HALF_DELAY = 2'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : spi_halt_pkg

// ===== spi_halt_port.sv
// Clock-halt serial port with bit clock generator and AXI4-Lite registers
//
// Functional notes
// R1: Bit clock period is divider plus one generator input periods; the code gives two periods for divider zero.
// R2: High phase is divider/2+1 when even, else (divider+1)/2 periods.
// R3: Low phase is divider/2 when even, else (divider+1)/2 periods; the code gives one period for divider zero.
// R4: Source select one feeds the divider with half the system clock.
// R5: Source select zero feeds the divider from the external sample clock pin.
// R6: Software sets source select and divider to one in slave modes.
// R7: Master with sync polarities set drives an active-low select output.
// R8: Slave inverts the active-low select received before internal use.
// R9: Master drives transmit clock and sync; receive clock and sync are inputs.
// R10: Slave takes all clocks and syncs as inputs.
// R11: Select goes low before the clock, transfer starts on rising edge.
// R12: Transmit bits launch on falling bit clock edges.
// R13: Receive bits are sampled on rising bit clock edges.
// R14: Half-delay mode with polarity zero: select leads by one full period.
// R15: No-delay mode with polarity one: select leads by one high phase.
// R16: Half-delay polarity zero: select holds one low phase after last fall.
// R17: Half-delay mode releases data output at the final falling edge.
// R18: No-delay master releases data output at the final rising edge; the code releases it one idle-level phase into the trail.
// R19: No-delay slave releases data output when select returns high.
// R20: Slave presents first bit when select falls, before any clock edge.
// R21: No-delay mode with polarity zero is also supported.
// R22: Idle master keeps bit clock at idle level and select deasserted.
`timescale 1ns/1ns

module spi_halt_port
	import spi_halt_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        sample_clock_pin,
	input  wire logic        tx_bit_clock_pin_level,
	output logic             tx_bit_clock_pin_value,
	output logic             tx_bit_clock_pin_oe,
	input  wire logic        tx_sync_pin_level,
	output logic             tx_sync_pin_value,
	output logic             tx_sync_pin_oe,
	input  wire logic        rx_sync_pin,
	input  wire logic        serial_in_pin,
	output logic             serial_out_pin_value,
	output logic             serial_out_pin_oe
);

	typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_TRAIL} seq_state_t;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [10:0]     ctrl_reg;
	logic [7:0]      div_reg;
	logic [7:0]      tx_buf_reg;
	logic [7:0]      rx_data_reg;
	logic            rx_ready_reg;
	logic            go_reg;
	logic            aw_hold_reg;
	logic            w_hold_reg;
	logic [4:0]      aw_addr_reg;
	logic [31:0]     w_data_reg;
	logic [3:0]      w_strb_reg;
	logic            bvalid_reg;
	logic [1:0]      bresp_reg;
	logic            rvalid_reg;
	logic [31:0]     rdata_reg;
	logic [1:0]      rresp_reg;
	logic            half_reg;
	logic [2:0]      ext_sync_reg;
	logic [2:0]      clk_sync_reg;
	logic [1:0]      sel_sync_reg;
	logic [1:0]      rxs_sync_reg;
	logic [1:0]      din_sync_reg;
	logic            slave_sel_reg;
	seq_state_t      state_reg;
	logic [8:0]      cnt_reg;
	logic [4:0]      edge_reg;
	logic            sclk_reg;
	logic            sel_reg;
	logic            sout_reg;
	logic            oe_reg;
	logic [7:0]      tx_shift_reg;
	logic [7:0]      rx_shift_reg;
	logic [3:0]      bits_reg;
	logic [8:0]      per_ticks_reg;
	logic            seen_rise_reg;
	logic            samp_reg;

	// ----------------------------------------------------------------
	// Control decode
	// ----------------------------------------------------------------
	wire       enable_w   = ctrl_reg[CTRL_ENABLE_BIT];
	wire [1:0] halt_mode  = ctrl_reg[CTRL_MODE_LSB +: 2];
	wire       txcp_w     = ctrl_reg[CTRL_TXCP_BIT];
	wire       rxsp_w     = ctrl_reg[CTRL_RXSP_BIT];
	wire       txsp_w     = ctrl_reg[CTRL_TXSP_BIT];
	wire       src_w      = ctrl_reg[CTRL_SRC_BIT];
	wire       txcd_w     = ctrl_reg[CTRL_TXCD_BIT];
	wire       rxcd_w     = ctrl_reg[CTRL_RXCD_BIT];
	wire       txsd_w     = ctrl_reg[CTRL_TXSD_BIT];
	wire       rxsd_w     = ctrl_reg[CTRL_RXSD_BIT];
	wire       halt_on_w  = enable_w && halt_mode[1];
	// R9: master drives transmit clock and sync, receive side is input
	wire       master_w   = halt_on_w && txcd_w && txsd_w && !rxcd_w && !rxsd_w;
	// R10: slave when all four direction bits are clear
	wire       slave_w    = halt_on_w && !txcd_w && !txsd_w && !rxcd_w && !rxsd_w;
	wire       half_dly_w = (halt_mode == HALT_HALF_DELAY);

	// ----------------------------------------------------------------
	// Bit clock generator
	// ----------------------------------------------------------------
	wire       ext_rise_w = ext_sync_reg[1] && !ext_sync_reg[2];
	// R4 R5: divider input is half system clock or the external pin
	wire       gen_tick_w = src_w ? half_reg : ext_rise_w;
	wire [8:0] div_ext    = {1'b0, div_reg};
	wire [8:0] div_up     = div_ext + 9'h001;
	// R2: high phase length in input ticks
	wire [8:0] high_len   = (div_reg == 8'h00) ? 9'h001 :
		div_reg[0] ? (div_up >> 1) : ((div_ext >> 1) + 9'h001);
	// R3: low phase length in input ticks
	wire [8:0] low_len    = (div_reg == 8'h00) ? 9'h001 :
		div_reg[0] ? (div_up >> 1) : (div_ext >> 1);
	// R1: full period is high plus low, divider plus one ticks, two ticks for divider zero
	wire [8:0] period_len = high_len + low_len;
	wire [8:0] idle_len   = txcp_w ? high_len : low_len;
	// R14 R15 R21: select lead before the first edge
	wire [8:0] lead_len   = half_dly_w ? period_len : idle_len;
	// R16: select hold after the last edge
	wire [8:0] trail_len  = half_dly_w ? idle_len : period_len;
	wire [8:0] phase_len  = (state_reg == ST_LEAD) ? lead_len :
		(state_reg == ST_TRAIL) ? trail_len : (sclk_reg ? high_len : low_len);
	wire       phase_end  = gen_tick_w && (cnt_reg == phase_len - 9'h001);
	wire       m_edge_w   = phase_end && ((state_reg == ST_LEAD) || (state_reg == ST_SHIFT));
	wire       last_edge  = m_edge_w && (edge_reg == 5'h0F);
	// R18: no-delay release one idle-level phase into the trail
	wire       trail_rel  = (state_reg == ST_TRAIL) && !half_dly_w && gen_tick_w &&
		(cnt_reg == idle_len - 9'h001);

	// ----------------------------------------------------------------
	// Slave select and edge events
	// ----------------------------------------------------------------
	// R8: active-low select is inverted before internal use
	wire       slave_sel_w = sel_sync_reg[1] ^ txsp_w;
	wire       s_rise_w    = clk_sync_reg[1] && !clk_sync_reg[2];
	wire       s_fall_w    = !clk_sync_reg[1] && clk_sync_reg[2];
	wire       s_start_w   = slave_w && slave_sel_w && !slave_sel_reg;
	wire       s_stop_w    = slave_w && !slave_sel_w && slave_sel_reg;
	wire       m_start_w   = master_w && go_reg && (state_reg == ST_IDLE);
	wire       rise_ev     = master_w ? (m_edge_w && !sclk_reg) :
		(slave_w && slave_sel_reg && s_rise_w);
	wire       fall_ev     = master_w ? (m_edge_w && sclk_reg) :
		(slave_w && slave_sel_reg && s_fall_w);
	wire       start_ev    = m_start_w || s_start_w;
	wire       bits_mid    = (bits_reg != 4'h0) && (bits_reg < WORD_BITS_C);
	wire       launch_ev   = fall_ev && bits_mid;
	wire       rise_take   = rise_ev && (bits_reg < WORD_BITS_C);
	// R13: taken one cycle late to cover the input synchroniser
	wire       sample_ev   = samp_reg && (bits_reg < WORD_BITS_C);
	wire       word_done   = sample_ev && (bits_reg == WORD_BITS_C - 4'h1);

	// ----------------------------------------------------------------
	// Register bus decode
	// ----------------------------------------------------------------
	wire        wr_fire   = aw_hold_reg && w_hold_reg && !bvalid_reg;
	wire [31:0] wmask     = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
		{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
	wire [31:0] ctrl_wide = {21'h000000, ctrl_reg};
	wire [31:0] ctrl_new  = (ctrl_wide & ~wmask) | (w_data_reg & wmask);
	wire        wr_ctrl   = wr_fire && (aw_addr_reg == CTRL_OFFSET);
	// R22: idle level follows a control write with no lag
	wire        idle_lvl_w = wr_ctrl ? ctrl_new[CTRL_TXCP_BIT] : txcp_w;
	wire        wr_div    = wr_fire && (aw_addr_reg == DIV_OFFSET) && w_strb_reg[0];
	wire        wr_tx     = wr_fire && (aw_addr_reg == TXDATA_OFFSET) && w_strb_reg[0];
	wire        wr_ok     = (aw_addr_reg == CTRL_OFFSET) || (aw_addr_reg == DIV_OFFSET) ||
		(aw_addr_reg == TXDATA_OFFSET) || (aw_addr_reg == RXDATA_OFFSET) ||
		(aw_addr_reg == STATUS_OFFSET);
	wire        rd_fire   = s_axi_arvalid && !rvalid_reg;
	wire [4:0]  rd_addr   = s_axi_araddr[4:0];
	wire        rd_hi_ok  = (s_axi_araddr[31:5] == 27'h0000000) && (rd_addr[1:0] == 2'h0);
	wire        wr_hi_ok  = 1'b1;
	wire        rd_rx     = rd_fire && rd_hi_ok && (rd_addr == RXDATA_OFFSET);
	wire [31:0] status_w  = {27'h0000000, (rxs_sync_reg[1] ^ rxsp_w), sclk_reg,
		(sel_reg || slave_sel_reg), rx_ready_reg, (state_reg != ST_IDLE) || go_reg};
	logic [31:0] rd_mux;
	logic        rd_hit;

	always_comb
	begin
		rd_mux = 32'h00000000;
		rd_hit = rd_hi_ok;
		case (rd_addr)
			CTRL_OFFSET:   rd_mux = ctrl_wide;
			DIV_OFFSET:    rd_mux = {24'h000000, div_reg};
			TXDATA_OFFSET: rd_mux = {24'h000000, tx_buf_reg};
			RXDATA_OFFSET: rd_mux = {24'h000000, rx_data_reg};
			STATUS_OFFSET: rd_mux = status_w;
			default:       rd_hit = 1'b0;
		endcase
	end

	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// ----------------------------------------------------------------
	// Bus write and read channels
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_reg <= 1'b0;
			w_hold_reg  <= 1'b0;
			aw_addr_reg <= 5'h00;
			w_data_reg  <= 32'h00000000;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= (s_axi_awaddr[31:5] == 27'h0000000) ? s_axi_awaddr[4:0] : 5'h1F;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire)
			begin
				aw_hold_reg <= 1'b0;
				w_hold_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= (wr_ok && wr_hi_ok) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_reg && s_axi_bready)
				bvalid_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h00000000;
			rresp_reg  <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_hit ? rd_mux : 32'h00000000;
			rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_reg && s_axi_rready)
			rvalid_reg <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Software registers and flags
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_reg     <= CTRL_RESET;
			div_reg      <= DIV_RESET;
			tx_buf_reg   <= 8'h00;
			go_reg       <= 1'b0;
			rx_data_reg  <= 8'h00;
			rx_ready_reg <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_reg <= ctrl_new[CTRL_WIDTH-1:0];
			if (wr_div)
				div_reg <= w_data_reg[7:0];
			if (wr_tx)
				tx_buf_reg <= w_data_reg[7:0];
			if (wr_tx && master_w)
				go_reg <= 1'b1;
			else if (m_start_w || !master_w)
				go_reg <= 1'b0;
			// Word completion wins over a clearing read
			if (word_done)
			begin
				rx_data_reg  <= {rx_shift_reg[6:0], din_sync_reg[1]};
				rx_ready_reg <= 1'b1;
			end
			else if (rd_rx)
				rx_ready_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Pin synchronisers and divider input
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			half_reg      <= 1'b0;
			ext_sync_reg  <= 3'h0;
			clk_sync_reg  <= 3'h0;
			sel_sync_reg  <= 2'h3;
			rxs_sync_reg  <= 2'h3;
			din_sync_reg  <= 2'h0;
			slave_sel_reg <= 1'b0;
		end
		else
		begin
			half_reg      <= !half_reg;
			ext_sync_reg  <= {ext_sync_reg[1:0], sample_clock_pin};
			clk_sync_reg  <= {clk_sync_reg[1:0], tx_bit_clock_pin_level};
			sel_sync_reg  <= {sel_sync_reg[0], tx_sync_pin_level};
			rxs_sync_reg  <= {rxs_sync_reg[0], rx_sync_pin};
			din_sync_reg  <= {din_sync_reg[0], serial_in_pin};
			slave_sel_reg <= slave_w && slave_sel_w;
		end
	end

	// ----------------------------------------------------------------
	// Master sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !master_w)
		begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 9'h000;
			edge_reg  <= 5'h00;
			sclk_reg  <= idle_lvl_w;
			sel_reg   <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					// R22: clock parked at idle level, select off
					sclk_reg <= idle_lvl_w;
					cnt_reg  <= 9'h000;
					edge_reg <= 5'h00;
					// R11: select asserted ahead of any clock edge
					if (m_start_w)
					begin
						sel_reg   <= 1'b1;
						state_reg <= ST_LEAD;
					end
				end
				ST_LEAD, ST_SHIFT:
				begin
					if (phase_end)
					begin
						cnt_reg  <= 9'h000;
						sclk_reg <= !sclk_reg;
						edge_reg <= edge_reg + 5'h01;
						state_reg <= last_edge ? ST_TRAIL : ST_SHIFT;
					end
					else if (gen_tick_w)
						cnt_reg <= cnt_reg + 9'h001;
				end
				ST_TRAIL:
				begin
					if (phase_end)
					begin
						sel_reg   <= 1'b0;
						state_reg <= ST_IDLE;
					end
					else if (gen_tick_w)
						cnt_reg <= cnt_reg + 9'h001;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Shared shift datapath
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sout_reg     <= 1'b0;
			oe_reg       <= 1'b0;
			tx_shift_reg <= 8'h00;
			rx_shift_reg <= 8'h00;
			bits_reg     <= 4'h0;
			samp_reg     <= 1'b0;
		end
		else if (start_ev)
		begin
			// R20: first bit driven as soon as select is active
			sout_reg     <= tx_buf_reg[7];
			tx_shift_reg <= {tx_buf_reg[6:0], 1'b0};
			oe_reg       <= 1'b1;
			bits_reg     <= 4'h0;
			samp_reg     <= 1'b0;
		end
		else
		begin
			samp_reg     <= rise_take;
			// R12: next bit launched on a falling edge
			if (launch_ev)
			begin
				sout_reg     <= tx_shift_reg[7];
				tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
			end
			// R13: input sampled on a rising edge
			if (sample_ev)
			begin
				rx_shift_reg <= {rx_shift_reg[6:0], din_sync_reg[1]};
				bits_reg     <= bits_reg + 4'h1;
			end
			// R17 R18 R19: output released at the last edge, one idle-level phase into the trail, or select end
			if ((last_edge && half_dly_w) || trail_rel || s_stop_w || (!master_w && !slave_w))
				oe_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	assign tx_bit_clock_pin_value = sclk_reg;
	assign tx_bit_clock_pin_oe    = master_w;
	// R7: select inverted onto the pin to give active low
	assign tx_sync_pin_value      = sel_reg ^ txsp_w;
	assign tx_sync_pin_oe         = master_w;
	assign serial_out_pin_value   = sout_reg;
	assign serial_out_pin_oe      = oe_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn || state_reg == ST_IDLE)
		begin
			per_ticks_reg <= 9'h000;
			seen_rise_reg <= 1'b0;
		end
		else if (rise_ev)
		begin
			per_ticks_reg <= 9'h000;
			seen_rise_reg <= 1'b1;
		end
		else if (gen_tick_w)
			per_ticks_reg <= per_ticks_reg + 9'h001;
	end

	AST_PERIOD: assert property (@(posedge aclk) disable iff (!aresetn) // R1
		master_w && rise_ev && seen_rise_reg |-> per_ticks_reg == period_len - 9'h001)
		else $error("Bit clock period wrong");
	AST_HIGH: assert property (@(posedge aclk) disable iff (!aresetn) // R2
		master_w && fall_ev && state_reg == ST_SHIFT |-> cnt_reg == high_len - 9'h001)
		else $error("High phase length wrong");
	AST_LOW: assert property (@(posedge aclk) disable iff (!aresetn) // R3
		master_w && rise_ev && state_reg == ST_SHIFT |-> cnt_reg == low_len - 9'h001)
		else $error("Low phase length wrong");
	AST_HALF_TICK: assert property (@(posedge aclk) disable iff (!aresetn) // R4
		src_w && $stable(src_w) && gen_tick_w |=> (!gen_tick_w || !src_w) ##1 (gen_tick_w || !src_w))
		else $error("Half clock tick rate wrong");
	AST_SEL_LOW: assert property (@(posedge aclk) disable iff (!aresetn) // R7
		master_w && txsp_w && state_reg != ST_IDLE |-> !tx_sync_pin_value)
		else $error("Select not active low");
	AST_SLAVE_DRIVE: assert property (@(posedge aclk) disable iff (!aresetn) // R20
		s_start_w |=> serial_out_pin_oe && serial_out_pin_value == $past(tx_buf_reg[7]))
		else $error("Slave first bit not driven");
	AST_DIR: assert property (@(posedge aclk) disable iff (!aresetn) // R10
		slave_w |-> !tx_bit_clock_pin_oe && !tx_sync_pin_oe)
		else $error("Slave drives clock or sync");
	AST_LAUNCH: assert property (@(posedge aclk) disable iff (!aresetn) // R12
		oe_reg && $past(oe_reg) && $changed(sout_reg) |-> $past(launch_ev))
		else $error("Data changed off a falling edge");
	AST_SAMPLE: assert property (@(posedge aclk) disable iff (!aresetn) // R13
		$changed(bits_reg) && bits_reg != 4'h0 |-> $past(rise_ev, 2))
		else $error("Sample off a rising edge");
	AST_SLAVE_REL: assert property (@(posedge aclk) disable iff (!aresetn) // R19
		s_stop_w |=> !serial_out_pin_oe)
		else $error("Slave output not released");
	AST_IDLE: assert property (@(posedge aclk) disable iff (!aresetn) // R22
		master_w && state_reg == ST_IDLE |-> sclk_reg == txcp_w && !sel_reg)
		else $error("Idle clock or select wrong");
	AST_MASTER_REL: assert property (@(posedge aclk) disable iff (!aresetn) // R17
		last_edge && half_dly_w |=> !serial_out_pin_oe && state_reg == ST_TRAIL)
		else $error("Master output not released");
	AST_HOLD_DATA: assert property (@(posedge aclk) disable iff (!aresetn) // R18
		master_w && !half_dly_w && last_edge |=> serial_out_pin_oe && state_reg == ST_TRAIL)
		else $error("Data released at the last edge");

endmodule : spi_halt_port

// ===== tb.sv
// Testbench for the clock-halt serial port
`timescale 1ns/1ns

module tb;
	import spi_halt_pkg::*;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, prv;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, miso;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        sample_clock_pin = 1'b0;
	logic        tx_bit_clock_pin_value, tx_bit_clock_pin_oe, tx_sync_pin_value;
	logic        tx_sync_pin_oe, serial_out_pin_value, serial_out_pin_oe;
	logic [7:0]  resp_byte, got_byte;
	int          mismatches, n_compared, run, hi_run, lo_run;
	wire tx_bit_clock_pin_level = tx_bit_clock_pin_oe ? tx_bit_clock_pin_value : 1'b0;
	wire tx_sync_pin_level = tx_sync_pin_oe ? tx_sync_pin_value : 1'b1;
	wire rx_sync_pin = tx_sync_pin_level;
	wire serial_in_pin = miso;
	wire mosi = serial_out_pin_oe ? serial_out_pin_value : ~serial_out_pin_value;

	spi_halt_port DUT (.*);
	spi_dev_model dev (.sclk(tx_bit_clock_pin_level), .sel_n(tx_sync_pin_level), .mosi(mosi),
		.resp_byte(resp_byte), .miso(miso), .got_byte(got_byte));

	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk) sample_clock_pin <= ~sample_clock_pin;
	// Phase widths of the bit clock in aclk cycles
	always @(posedge aclk)
	begin
		prv <= tx_bit_clock_pin_value;
		if (tx_bit_clock_pin_value === prv) run <= run + 1;
		else
		begin
			if (prv) hi_run <= run;
			else lo_run <= run;
			run <= 1;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t %s: got %h exp %h", $time, m, seen, exp);
		end
	endtask : chk

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : wrap_up

	task automatic hang();
		mismatches++;
		wrap_up();
	endtask : hang

	task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		int i;
		s_axi_awaddr <= {27'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (i == 20) hang();
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		s_axi_araddr <= {27'h0, a};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (i == 20) hang();
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	task automatic test_regs();
		logic [31:0] d;
		logic [1:0]  r;
		rd(CTRL_OFFSET, d, r);
		chk(d, {21'h0, CTRL_RESET}, "ctrl reset");
		rd(DIV_OFFSET, d, r);
		chk(d, {24'h0, DIV_RESET}, "div reset");
		rd(5'h14, d, r);
		chk({d[29:0], r}, {30'h0, RESP_SLVERR}, "unmapped read");
		wr(5'h14, 32'h0000_00FF, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
		chk(32'({tx_bit_clock_pin_oe, tx_sync_pin_oe, serial_out_pin_oe}), 0, "idle oe");
		$display("test_regs done");
	endtask : test_regs

	task automatic test_xfer(input logic [10:0] ctrl, input logic [7:0] div, input logic [7:0] tx,
		input logic [7:0] rx, input int hi, input int lo);
		logic [31:0] d;
		logic [1:0]  r;
		int          i;
		resp_byte = rx;
		wr(CTRL_OFFSET, {21'h0, ctrl}, r);
		wr(DIV_OFFSET, {24'h0, div}, r);
		chk(32'(tx_bit_clock_pin_value), 32'(ctrl[CTRL_TXCP_BIT]), "idle clock");
		chk(32'({tx_bit_clock_pin_oe, tx_sync_pin_oe}), 32'h3, "master pins");
		wr(TXDATA_OFFSET, {24'h0, tx}, r);
		for (i = 0; i < 20 && tx_sync_pin_value !== 1'b0; i++) @(posedge aclk);
		if (i == 20) hang();
		for (i = 0; i < 500 && tx_sync_pin_value !== 1'b1; i++) @(posedge aclk);
		if (i == 500) hang();
		@(posedge aclk);
		rd(RXDATA_OFFSET, d, r);
		chk(d, {24'h0, rx}, "rx word");
		chk({24'h0, got_byte}, {24'h0, tx}, "tx word");
		chk(32'(hi_run), 32'(hi), "high phase");
		chk(32'(lo_run), 32'(lo), "low phase");
		chk(32'(serial_out_pin_oe), 0, "data release");
		chk(32'({tx_bit_clock_pin_value, tx_sync_pin_value}), 32'({ctrl[3], 1'b1}), "idle");
		$display("test_xfer %h done", ctrl);
	endtask : test_xfer

	initial
	begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		resp_byte = 8'h00;
		mismatches = 0;
		n_compared = 0;
		run = 0;
		hi_run = 0;
		lo_run = 0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		test_regs();
		test_xfer(11'h2F7, 8'h01, 8'hA5, 8'h3C, 2, 2);
		test_xfer(11'h2FD, 8'h02, 8'h5A, 8'hC3, 4, 2);
		test_xfer(11'h2F5, 8'h03, 8'h81, 8'h7E, 4, 4);
		test_xfer(11'h2B7, 8'h01, 8'h96, 8'h69, 2, 2);
		wrap_up();
	end
endmodule : tb
